/* File: clock_prescaler_pkg.sv */
// constants for the clock source, start-up timer and system prescaler
package clock_prescaler_pkg;
  // register byte offsets
  localparam logic [3:0] TRIM_OFFSET = 4'h0;
  localparam logic [3:0] PRESCALE_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 3;
  // field positions
  localparam int TRIM_MSB = 6;
  localparam int UNLOCK_BIT = 7;
  localparam int SELECT_MSB = 3;
  // unlock pattern and window
  localparam logic [7:0] UNLOCK_PATTERN = 8'h80;
  localparam logic [1:0] UNLOCK_LAST = 2'h3;
  // select codes
  localparam logic [3:0] SELECT_DIV1 = 4'h0;
  localparam logic [3:0] SELECT_DIV8 = 4'h3;
  localparam logic [3:0] SELECT_MAX = 4'h8;
  localparam int PRESCALE_WIDTH = 8;
  // fuse encodings, zero means programmed
  localparam logic [1:0] SOURCE_RC_FULL = 2'h2;
  localparam logic [1:0] SOURCE_RC_HALF = 2'h1;
  localparam logic [1:0] SOURCE_LOW_POWER = 2'h3;
  localparam logic [1:0] STARTUP_NONE = 2'h0;
  localparam logic [1:0] STARTUP_SHORT = 2'h1;
  localparam logic [1:0] STARTUP_LONG = 2'h2;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  // start-up cycle counts in source clocks
  localparam logic [3:0] WAKE_CYCLES = 4'h6;
  localparam logic [3:0] RESET_CYCLES = 4'he;
  // reset delay times in watchdog oscillator terms
  localparam int WDT_OSC_KHZ = 128;
  localparam int SHORT_DELAY_MS = 4;
  localparam int LONG_DELAY_MS = 64;
  localparam int SHORT_DELAY_TICKS = SHORT_DELAY_MS * WDT_OSC_KHZ;
  localparam int LONG_DELAY_TICKS = LONG_DELAY_MS * WDT_OSC_KHZ;
  localparam int DELAY_WIDTH = 14;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // start-up sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_WDT_WAIT = 5'h01,
    ST_CK_WAIT = 5'h02,
    ST_RUN = 5'h04,
    ST_SLEEP = 5'h08,
    ST_WAKE = 5'h10
  } startup_state_type;
endpackage

/* File: clock_source_and_prescaler.sv */
// clock source selection, start-up timer, trim and system prescaler
module clock_source_and_prescaler #(
  parameter logic [1:0] CLOCK_SOURCE_SELECT_FUSES = clock_prescaler_pkg::SOURCE_RC_FULL,
  parameter logic [1:0] STARTUP_TIME_FUSES = clock_prescaler_pkg::STARTUP_LONG,
  parameter logic DIVIDE_BY_EIGHT_FUSE = clock_prescaler_pkg::FUSE_PROGRAMMED,
  parameter logic [6:0] FACTORY_CALIBRATION = 7'h40,
  parameter int SHORT_DELAY_TICKS = clock_prescaler_pkg::SHORT_DELAY_TICKS,
  parameter int LONG_DELAY_TICKS = clock_prescaler_pkg::LONG_DELAY_TICKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // oscillator ticks and power state
  input wire logic wdt_tick_i,
  input wire logic ext_tick_i,
  input wire logic power_down_i,
  // generated clock enables and status
  output logic sys_clk_en_o,
  output logic startup_done_o,
  output logic [6:0] trim_o,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // mask of counter bits that must be all ones for a divided tick
  function automatic logic [7:0] select_mask(input logic [3:0] sel);
    select_mask = 8'(({8'h0, 1'b1} << sel) - 9'h1);
  endfunction

  // address decode for the write response, the read path decodes in its own case
  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == clock_prescaler_pkg::TRIM_OFFSET) ||
                (addr == clock_prescaler_pkg::PRESCALE_OFFSET) ||
                (addr == clock_prescaler_pkg::STATUS_OFFSET);
  endfunction

  // bus side state
  logic [3:0] wr_addr_reg; // held write address
  logic [7:0] wr_data_reg; // held write data, low byte
  logic wr_strb_reg; // lane 0 enabled
  logic do_write; // both halves held, response free
  logic prescale_wr; // write to prescale register
  // clock side state
  logic [6:0] trim_reg; // oscillator trim
  logic unlock_reg; // prescale change unlock
  logic [1:0] unlock_cnt_reg; // unlock window counter
  logic [3:0] select_reg; // software visible select
  logic [3:0] active_sel_reg; // select in force
  logic pend_reg; // new select waiting for period end
  logic [7:0] ripple_reg; // prescaler counter
  logic half_reg; // divide-by-two phase
  logic src_tick; // undivided source clock enable
  logic div_hit; // end of a divided period
  clock_prescaler_pkg::startup_state_type state_reg;
  logic [clock_prescaler_pkg::DELAY_WIDTH-1:0] wdt_cnt_reg; // watchdog ticks
  logic [3:0] ck_cnt_reg; // source ticks during start-up
  logic [clock_prescaler_pkg::DELAY_WIDTH-1:0] wdt_target; // reset delay length

  // source select decode
  always_comb begin
    case (CLOCK_SOURCE_SELECT_FUSES)
      clock_prescaler_pkg::SOURCE_RC_FULL: src_tick = 1'b1;
      clock_prescaler_pkg::SOURCE_RC_HALF: src_tick = half_reg;
      clock_prescaler_pkg::SOURCE_LOW_POWER: src_tick = wdt_tick_i;
      default: src_tick = ext_tick_i;
    endcase
    // oscillator stopped while asleep
    if (state_reg == clock_prescaler_pkg::ST_SLEEP) begin
      src_tick = 1'b0;
    end
  end

  // divide-by-two phase for the half rate mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  // reset delay length in watchdog ticks
  always_comb begin
    if (STARTUP_TIME_FUSES == clock_prescaler_pkg::STARTUP_SHORT) begin
      wdt_target = clock_prescaler_pkg::DELAY_WIDTH'(SHORT_DELAY_TICKS - 1);
    end else begin
      wdt_target = clock_prescaler_pkg::DELAY_WIDTH'(LONG_DELAY_TICKS - 1);
    end
  end

  // start-up sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wdt_cnt_reg <= '0;
      ck_cnt_reg <= 4'h0;
      // no real-time delay for code 00
      if (STARTUP_TIME_FUSES == clock_prescaler_pkg::STARTUP_NONE) begin
        state_reg <= clock_prescaler_pkg::ST_CK_WAIT;
      end else begin
        state_reg <= clock_prescaler_pkg::ST_WDT_WAIT;
      end
    end else begin
      case (state_reg)
        // watchdog oscillator times the reset delay
        clock_prescaler_pkg::ST_WDT_WAIT: begin
          if (wdt_tick_i) begin
            wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
            if (wdt_cnt_reg == wdt_target) begin
              state_reg <= clock_prescaler_pkg::ST_CK_WAIT;
            end
          end
        end
        clock_prescaler_pkg::ST_CK_WAIT: begin
          if (src_tick) begin
            ck_cnt_reg <= ck_cnt_reg + 1'b1;
            if (ck_cnt_reg == clock_prescaler_pkg::RESET_CYCLES - 4'h1) begin
              state_reg <= clock_prescaler_pkg::ST_RUN;
            end
          end
        end
        // running, watch for power-down
        clock_prescaler_pkg::ST_RUN: begin
          ck_cnt_reg <= 4'h0;
          if (power_down_i) begin
            state_reg <= clock_prescaler_pkg::ST_SLEEP;
          end
        end
        // oscillator stopped
        clock_prescaler_pkg::ST_SLEEP: begin
          if (!power_down_i) begin
            state_reg <= clock_prescaler_pkg::ST_WAKE;
          end
        end
        clock_prescaler_pkg::ST_WAKE: begin
          if (src_tick) begin
            ck_cnt_reg <= ck_cnt_reg + 1'b1;
            if (ck_cnt_reg == clock_prescaler_pkg::WAKE_CYCLES - 4'h1) begin
              state_reg <= clock_prescaler_pkg::ST_RUN;
            end
          end
        end
        default: state_reg <= clock_prescaler_pkg::ST_CK_WAIT;
      endcase
    end
  end

  // ripple counter on the undivided source, never read back
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ripple_reg <= '0;
    end else if (src_tick) begin
      if (div_hit && pend_reg) begin
        ripple_reg <= '0;
      end else begin
        ripple_reg <= ripple_reg + 1'b1;
      end
    end
  end

  // end of the current divided period
  assign div_hit = src_tick && ((ripple_reg & select_mask(active_sel_reg)) == select_mask(active_sel_reg));

  // one enable drives cpu, io, adc and flash
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sys_clk_en_o <= 1'b0;
    end else begin
      sys_clk_en_o <= div_hit && (state_reg == clock_prescaler_pkg::ST_RUN);
    end
  end

  // start-up finished flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      startup_done_o <= 1'b0;
    end else begin
      startup_done_o <= (state_reg == clock_prescaler_pkg::ST_RUN);
    end
  end

  // trim loaded with calibration at every reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      trim_reg <= FACTORY_CALIBRATION;
    end else if (do_write && wr_strb_reg && wr_addr_reg == clock_prescaler_pkg::TRIM_OFFSET) begin
      trim_reg <= wr_data_reg[clock_prescaler_pkg::TRIM_MSB:0];
    end
  end
  assign trim_o = trim_reg;

  // write to the prescale register this cycle
  assign prescale_wr = do_write && wr_strb_reg && (wr_addr_reg == clock_prescaler_pkg::PRESCALE_OFFSET);

  // unlock bit and its four cycle window
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= 2'h0;
    end else if (!unlock_reg) begin
      // only the exact pattern sets it
      if (prescale_wr && wr_data_reg == clock_prescaler_pkg::UNLOCK_PATTERN) begin
        unlock_reg <= 1'b1;
        unlock_cnt_reg <= 2'h0;
      end
    end else if (prescale_wr && !wr_data_reg[clock_prescaler_pkg::UNLOCK_BIT]) begin
      unlock_reg <= 1'b0;
    end else if (unlock_cnt_reg == clock_prescaler_pkg::UNLOCK_LAST) begin
      unlock_reg <= 1'b0;
    end else begin
      unlock_cnt_reg <= unlock_cnt_reg + 1'b1;
    end
  end

  // software visible select and pending flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // start divided by eight when fuse programmed
      if (DIVIDE_BY_EIGHT_FUSE == clock_prescaler_pkg::FUSE_PROGRAMMED) begin
        select_reg <= clock_prescaler_pkg::SELECT_DIV8;
      end else begin
        select_reg <= clock_prescaler_pkg::SELECT_DIV1;
      end
      pend_reg <= 1'b0;
    end else if (prescale_wr && unlock_reg && !wr_data_reg[clock_prescaler_pkg::UNLOCK_BIT] &&
                 wr_data_reg[clock_prescaler_pkg::SELECT_MSB:0] <= clock_prescaler_pkg::SELECT_MAX) begin
      select_reg <= wr_data_reg[clock_prescaler_pkg::SELECT_MSB:0];
      pend_reg <= 1'b1;
    end else if (div_hit) begin
      pend_reg <= 1'b0;
    end
  end

  // new factor applied only at the end of the old period
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      if (DIVIDE_BY_EIGHT_FUSE == clock_prescaler_pkg::FUSE_PROGRAMMED) begin
        active_sel_reg <= clock_prescaler_pkg::SELECT_DIV8;
      end else begin
        active_sel_reg <= clock_prescaler_pkg::SELECT_DIV1;
      end
    end else if (div_hit && pend_reg) begin
      active_sel_reg <= select_reg;
    end
  end

  // write channels: take address and data in either order
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clock_prescaler_pkg::RESP_OKAY;
      wr_addr_reg <= 4'h0;
      wr_data_reg <= 8'h0;
      wr_strb_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr_reg <= {s_axi_awaddr[clock_prescaler_pkg::ADDR_MSB:clock_prescaler_pkg::ADDR_LSB], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data_reg <= s_axi_wdata[7:0];
        wr_strb_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr_reg) ? clock_prescaler_pkg::RESP_OKAY : clock_prescaler_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register write happens once both halves are held
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // read channel, answer one cycle after the address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= clock_prescaler_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= clock_prescaler_pkg::RESP_OKAY;
      case ({s_axi_araddr[clock_prescaler_pkg::ADDR_MSB:clock_prescaler_pkg::ADDR_LSB], 2'h0})
        clock_prescaler_pkg::TRIM_OFFSET: s_axi_rdata <= {25'h0, trim_reg};
        clock_prescaler_pkg::PRESCALE_OFFSET: s_axi_rdata <= {24'h0, unlock_reg, 3'h0, select_reg};
        // start-up state, active select, fuses
        clock_prescaler_pkg::STATUS_OFFSET: s_axi_rdata <= {19'h0, DIVIDE_BY_EIGHT_FUSE, STARTUP_TIME_FUSES,
          CLOCK_SOURCE_SELECT_FUSES, active_sel_reg, 2'h0, pend_reg, startup_done_o};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= clock_prescaler_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  sequence unlock_write_s;
    prescale_wr && !unlock_reg && wr_data_reg == clock_prescaler_pkg::UNLOCK_PATTERN;
  endsequence
  // no prescale write for the whole unlock window
  sequence unlock_hold_s;
    !prescale_wr [*4];
  endsequence

  unlock_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    unlock_write_s |=> unlock_reg) else $error("unlock not set by pattern write");
  unlock_window_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    unlock_write_s ##1 unlock_hold_s |=> !unlock_reg && $past(unlock_reg) && $past(unlock_reg, 4))
    else $error("unlock window wrong");
  unlock_timeout_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(unlock_reg) |-> ##[1:4] !unlock_reg) else $error("unlock outlived four cycles");
  bad_unlock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (prescale_wr && !unlock_reg && wr_data_reg != clock_prescaler_pkg::UNLOCK_PATTERN) |=> !unlock_reg)
    else $error("unlock set by wrong pattern");
  trim_reset_a: assert property (@(posedge clk_i)
    $fell(sys_rst_i) |-> trim_reg == FACTORY_CALIBRATION) else $error("trim not calibrated at reset");
  select_reset_a: assert property (@(posedge clk_i)
    $fell(sys_rst_i) |-> active_sel_reg == ((DIVIDE_BY_EIGHT_FUSE == clock_prescaler_pkg::FUSE_PROGRAMMED)
      ? clock_prescaler_pkg::SELECT_DIV8 : clock_prescaler_pkg::SELECT_DIV1)) else $error("select reset wrong");
  select_range_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    select_reg <= clock_prescaler_pkg::SELECT_MAX && active_sel_reg <= clock_prescaler_pkg::SELECT_MAX)
    else $error("reserved select in force");
  locked_select_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!unlock_reg && !pend_reg) |=> $stable(select_reg) || $past(sys_rst_i)) else $error("select changed while locked");
  switch_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$stable(active_sel_reg) |-> $past(div_hit)) else $error("select applied mid period");
  no_clock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sys_clk_en_o |-> $past(state_reg) == clock_prescaler_pkg::ST_RUN) else $error("clock before start-up");
  half_rate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (CLOCK_SOURCE_SELECT_FUSES == clock_prescaler_pkg::SOURCE_RC_HALF && src_tick) |=> !src_tick)
    else $error("half rate source ran at full rate");
  trim_top_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready) &&
     {$past(s_axi_araddr[clock_prescaler_pkg::ADDR_MSB:clock_prescaler_pkg::ADDR_LSB]), 2'h0} ==
     clock_prescaler_pkg::TRIM_OFFSET) |-> s_axi_rdata[31:7] == 25'h0) else $error("trim read has bit 7 set");

endmodule

/* File: clock_source_and_prescaler_tb.sv */
// self-checking bench for the clock source, trim and prescaler block
module clock_source_and_prescaler_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // calibration handed to the design, arbitrary
  localparam logic [6:0] CAL = 7'h40;
  // clock, reset and oscillator ticks
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wdt_tick_i = 1'b0;
  logic ext_tick_i = 1'b0;
  logic power_down_i = 1'b0;
  // design outputs
  logic sys_clk_en_o;
  logic startup_done_o;
  logic [6:0] trim_o;
  // register bus
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // bench bookkeeping
  int n_errors = 0;
  int comparisons = 0;
  integer seed = 32'he17fbc76;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [31:0] val;
  int per;
  int n;

  // short reset delays keep the start-up brief
  clock_source_and_prescaler #(.SHORT_DELAY_TICKS(4), .LONG_DELAY_TICKS(8), .FACTORY_CALIBRATION(CAL))
    clock_source_and_prescaler_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wdt_tick_i(wdt_tick_i),
    .ext_tick_i(ext_tick_i), .power_down_i(power_down_i), .sys_clk_en_o(sys_clk_en_o),
    .startup_done_o(startup_done_o), .trim_o(trim_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // random watchdog and external oscillator ticks
  always @(posedge clk_i) begin
    wdt_tick_i <= ($random(seed) & 3) == 0;
    ext_tick_i <= ($random(seed) & 3) == 0;
  end

  // expected status word for the shipped fuse settings
  function automatic logic [31:0] exp_status(input logic [3:0] sel);
    return {19'h0, clock_prescaler_pkg::FUSE_PROGRAMMED, clock_prescaler_pkg::STARTUP_LONG,
            clock_prescaler_pkg::SOURCE_RC_FULL, sel, 4'h1};
  endfunction

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one write, entered just after a rising edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      // response ready only once both halves are taken
      if (!s_axi_bready && !(s_axi_awvalid && !s_axi_awready) && !(s_axi_wvalid && !s_axi_wready)) begin
        s_axi_bready <= 1'b1;
      end
    end while (!(s_axi_bvalid && s_axi_bready) && k < 200);
    // a write that never answers counts as a mismatch
    if (!(s_axi_bvalid && s_axi_bready)) n_errors++;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read, entered just after a rising edge
  task automatic axi_read(input logic [3:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
      end
    end while (!(s_axi_rvalid && s_axi_rready) && k < 200);
    // a read that never answers counts as a mismatch
    if (!(s_axi_rvalid && s_axi_rready)) n_errors++;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // wait for the next clock enable pulse, bounded
  task automatic wait_pulse;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (sys_clk_en_o !== 1'b1 && k < 1000);
  endtask

  // distance between two settled enable pulses
  task automatic measure;
    wait_pulse();
    wait_pulse();
    per = 0;
    do begin
      @(posedge clk_i);
      per++;
    end while (sys_clk_en_o !== 1'b1 && per < 1000);
  endtask

  // writes never interrupted
  // unlock, then select, back to back
  task automatic change_select(input logic [3:0] sel);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h80, 4'hf);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, {28'h0, sel}, 4'hf);
  endtask

  // prescale register must still hold code 2
  task automatic expect_select_two(input string what);
    axi_read(clock_prescaler_pkg::PRESCALE_OFFSET);
    check(what, rd, 32'h2);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    check("trim_o at reset", {25'h0, trim_o}, {25'h0, CAL});
    n = 0;
    while (startup_done_o !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    check("startup_done_o", {31'h0, startup_done_o}, 32'h1);
    axi_read(clock_prescaler_pkg::TRIM_OFFSET);
    check("trim reset value", rd, {25'h0, CAL});
    axi_read(clock_prescaler_pkg::PRESCALE_OFFSET);
    check("prescale reset value", rd, 32'h3);
    axi_read(clock_prescaler_pkg::STATUS_OFFSET);
    check("status fuses", rd, exp_status(4'h3));
    measure();
    check("start-up period", per, 8);
    $display("test reset and start-up done");
    // random trims, bit 7 always set to see it read back zero
    val = {25'h0, CAL};
    for (int i = 0; i < 6; i++) begin
      val = ((val & 32'h7f) + ($random(seed) & 32'hf) - 32'h8) | 32'h80;
      axi_write(clock_prescaler_pkg::TRIM_OFFSET, val, 4'hf);
      check("trim write resp", {30'h0, resp}, {30'h0, clock_prescaler_pkg::RESP_OKAY});
      axi_read(clock_prescaler_pkg::TRIM_OFFSET);
      check("trim readback", rd, {25'h0, val[6:0]});
      check("trim_o", {25'h0, trim_o}, {25'h0, val[6:0]});
    end
    axi_write(clock_prescaler_pkg::TRIM_OFFSET, val ^ 32'h10, 4'h0);
    check("trim with no strobe", {25'h0, trim_o}, {25'h0, val[6:0]});
    $display("test trim done");
    for (int k = 0; k <= 8; k++) begin
      change_select(k[3:0]);
      measure();
      check("divided period", per, 1 << k);
      axi_read(clock_prescaler_pkg::PRESCALE_OFFSET);
      check("select readback", rd, k);
    end
    change_select(4'h2);
    measure();
    check("period after 256 to 4", per, 4);
    $display("test select codes done");
    // reserved code is ignored and consumes the unlock
    change_select(4'h9);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h5, 4'hf);
    expect_select_two("reserved code");
    // select write without unlock
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h5, 4'hf);
    expect_select_two("no unlock");
    // unlock together with other bits does not unlock
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h81, 4'hf);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h5, 4'hf);
    expect_select_two("impure unlock");
    // unlock expires after its window
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h80, 4'hf);
    repeat (6) @(posedge clk_i);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h5, 4'hf);
    expect_select_two("expired unlock");
    // rewriting the unlock does not extend the window
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h80, 4'hf);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h80, 4'hf);
    axi_write(clock_prescaler_pkg::PRESCALE_OFFSET, 32'h5, 4'hf);
    expect_select_two("unlock rewrite");
    measure();
    check("period kept", per, 4);
    $display("test unlock sequence done");
    // unmapped address
    axi_read(4'hc);
    check("unmapped resp", {30'h0, resp}, {30'h0, clock_prescaler_pkg::RESP_SLVERR});
    check("unmapped data", rd, 32'h0);
    axi_write(4'hc, 32'h1, 4'hf);
    check("unmapped write resp", {30'h0, resp}, {30'h0, clock_prescaler_pkg::RESP_SLVERR});
    // power-down stops the enables, wake restores the rate
    power_down_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (50) begin
      @(posedge clk_i);
      if (sys_clk_en_o !== 1'b0) n++;
    end
    check("pulses in power-down", n, 0);
    power_down_i <= 1'b0;
    measure();
    check("period after wake", per, 4);
    $display("test bus error and power-down done");
    wrap_up();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #(25 * 40000);
    n_errors++;
    wrap_up();
  end
endmodule
